// file: bench/prs_link_checker.sv
// checker: timing relations on the pins between the power unit and the processor
`timescale 1ns/10ps
`default_nettype none
module prs_link_checker #(
  parameter int HOLD_CYC  = 50,
  parameter int F2R_CYC   = 5,
  parameter int CORE_CYC  = 40,
  parameter int LVREL_CYC = 50,
  parameter int HV_CYC    = 10,
  parameter int CNT_CYC   = 50
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // link pins
  input wire logic high_voltage_supply_enable,
  input wire logic low_voltage_supply_enable,
  input wire logic battery_fault_n,
  input wire logic core_supply_fault_n,
  input wire logic reset_out_n
);
  localparam int F2R_MAX  = F2R_CYC + 3;
  localparam int CORE_MAX = CORE_CYC + 10;
  logic [15:0] rlow_q;
  logic [15:0] lv_q;
  logic [15:0] hv_q;
  logic [15:0] ok_q;
  logic        ro_q;

  // run length of a level; saturates so a long idle never wraps into a false pass
  function automatic logic [15:0] run(input logic on, input logic [15:0] c);
    run = !on ? 16'h0000 : ((c == 16'hFFFF) ? c : c + 16'h0001);
  endfunction

  // how long each pin or pin pair has stood at its level
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rlow_q <= 16'h0000;
      lv_q   <= 16'h0000;
      hv_q   <= 16'h0000;
      ok_q   <= 16'h0000;
      ro_q   <= 1'b0;
    end else begin
      rlow_q <= run(!reset_out_n, rlow_q);
      lv_q   <= run(low_voltage_supply_enable, lv_q);
      hv_q   <= run(high_voltage_supply_enable, hv_q);
      ok_q   <= run(!(reset_out_n && !ro_q), ok_q); // cycles since reset output last rose
      ro_q   <= reset_out_n;
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // supply good while the processor still runs, then the reset pulse
  sequence s_flt_rel;
    $rose(battery_fault_n) && reset_out_n;
  endsequence
  sequence s_rst_fall;
    reset_out_n[*2] ##[1:F2R_MAX] !reset_out_n;
  endsequence

  a_rst_min_low: assert property ($rose(reset_out_n) |-> rlow_q >= HOLD_CYC)
    else $error("reset output released too early");
  a_rst_after_flt: assert property (s_flt_rel |-> s_rst_fall)
    else $error("reset not asserted after battery fault release");
  a_core_needs_lv: assert property ($rose(core_supply_fault_n) |-> lv_q >= CORE_CYC && battery_fault_n)
    else $error("core fault released without low-voltage enable");
  a_core_in_time: assert property (lv_q == CORE_MAX && battery_fault_n |-> core_supply_fault_n)
    else $error("core fault not released in time");
  a_rst_rel_lv: assert property ($rose(reset_out_n) && low_voltage_supply_enable |-> lv_q >= LVREL_CYC)
    else $error("reset released too soon after low-voltage enable");
  a_hv_needs_ok: assert property ($rose(high_voltage_supply_enable) |-> $past(battery_fault_n, 2))
    else $error("high-voltage enable without supply");
  a_hv_wait_rst: assert property ($rose(high_voltage_supply_enable) |-> $past(ok_q, 2) >= HV_CYC - 2)
    else $error("high-voltage enable too soon after reset release");
  a_lv_after_hv: assert property ($rose(low_voltage_supply_enable) |-> high_voltage_supply_enable && hv_q >= CNT_CYC)
    else $error("low-voltage enable too soon");
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// testbench: both ends joined, codes, sequencing, host registers and hardware reset
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import prs_pkg::*;
  typedef struct packed {logic [4:0] ctrl; logic main; logic [9:0] ua; logic [2:0] thr;} prs_row_t;
  logic        clock_i   = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        main_i    = 1'b0;
  logic        vin_ok_i  = 1'b0;
  logic        vin_low_i = 1'b1;
  logic        rtc_ok_i  = 1'b0;
  logic        rin_n_i   = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        rtc_main;
  logic        chg_en;
  logic [9:0]  ua;
  logic [2:0]  thr;
  logic        io_on;
  logic        core_on;
  logic [2:0]  st;
  logic [31:0] r;
  logic        e;
  int          errors    = 0;
  int          checked   = 0;
  // code 3 is reserved and reads 0; threshold 7 lies above the table and clamps to 5
  prs_row_t rows [4] = '{'{5'h00, 1'b0, 10'h177, 3'h0}, '{5'h0D, 1'b1, 10'h1F4, 3'h3},
                         '{5'h16, 1'b1, 10'h271, 3'h5}, '{5'h1F, 1'b0, 10'h000, 3'h5}};

  prs_link_if i_prs_link_if ();
  wire logic ro = i_prs_link_if.reset_out_n;
  wire logic bf = i_prs_link_if.battery_fault_n;
  wire logic cf = i_prs_link_if.core_supply_fault_n;
  wire logic hv = i_prs_link_if.high_voltage_supply_enable;
  wire logic lv = i_prs_link_if.low_voltage_supply_enable;

  // short counts keep the millisecond sequence inside a brief run
  localparam int unsigned T_LONG = 50;
  localparam int unsigned T_F2R  = 5;
  localparam int unsigned T_CORE = 40;
  localparam int unsigned T_HV   = 10;
  prs_dev #(.HOLD_CYC(T_LONG), .F2R_CYC(T_F2R), .CORE_CYC(T_CORE), .LVREL_CYC(T_LONG)) i_prs_dev (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .link(i_prs_link_if), .main_batt_present_i(main_i),
    .vin_above_release_i(vin_ok_i), .vin_below_assert_i(vin_low_i), .rtc_supply_valid_i(rtc_ok_i),
    .reset_in_n_i(rin_n_i), .rtc_from_main_o(rtc_main), .backup_charge_en_o(chg_en), .charge_ua_o(ua),
    .threshold_code_o(thr), .io_group_on_o(io_on), .core_group_on_o(core_on), .seq_state_o(st));
  prs_host #(.HV_CYC(T_HV), .CNT_CYC(T_LONG)) i_prs_host (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .link(i_prs_link_if), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_o(irq));
  prs_link_checker #(.HOLD_CYC(T_LONG), .F2R_CYC(T_F2R), .CORE_CYC(T_CORE), .LVREL_CYC(T_LONG), .HV_CYC(T_HV),
    .CNT_CYC(T_LONG)) i_prs_link_checker (.clock_i(clock_i), .rst_n_i(rst_n_i), .high_voltage_supply_enable(hv),
    .low_voltage_supply_enable(lv), .battery_fault_n(bf), .core_supply_fault_n(cf), .reset_out_n(ro));

  // 20 MHz clock
  always #25 clock_i = ~clock_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) errors++;
  endtask

  // bounded wait for the link to reach its running state
  task automatic wait_up();
    int n;
    for (n = 0; n < 5000 && !(cf === 1'b1 && ro === 1'b1 && lv === 1'b1); n++) @(posedge clock_i);
  endtask

  task automatic close_out();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog, well beyond two full start-ups
  initial begin
    repeat (60000) @(posedge clock_i);
    errors++;
    close_out();
  end

  initial begin
    int n;
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    chk({26'h0, ro, bf, cf, hv, lv, irq}, 32'h0);
    foreach (rows[i]) begin
      main_i <= rows[i].main;
      apb(1'b1, REG_CTRL, {27'h0, rows[i].ctrl});
      repeat (12) @(posedge clock_i);
      chk({22'h0, ua}, {22'h0, rows[i].ua});
      chk({29'h0, thr}, {29'h0, rows[i].thr});
      chk({30'h0, rtc_main, chg_en}, {30'h0, {2{rows[i].main}}});
    end
    // cold start with the supply still too low
    main_i <= 1'b1;
    rtc_ok_i <= 1'b1;
    apb(1'b1, REG_IRQ_EN, 32'h7);
    repeat (40) @(posedge clock_i);
    chk({31'h0, ro}, 32'h0);
    chk({31'h0, bf}, 32'h0);
    for (n = 0; n < 100 && ro !== 1'b1; n++) @(posedge clock_i);
    chk({31'h0, ro}, 32'h1);
    vin_ok_i <= 1'b1;
    vin_low_i <= 1'b0;
    wait_up();
    // state index lags the reset release by a register stage; group outputs are already on
    repeat (3) @(posedge clock_i);
    chk({29'h0, cf, hv, lv}, 32'h7);
    chk({30'h0, io_on, core_on}, 32'h3);
    chk({29'h0, st}, 32'h5);
    // interrupt raised, masked, cleared
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk({31'h0, r[0]}, 32'h1);
    apb(1'b1, REG_IRQ_EN, 32'h0);
    repeat (3) @(posedge clock_i);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, REG_IRQ_CLR, 32'h7);
    apb(1'b1, REG_IRQ_EN, 32'h7);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk(r, 32'h0);
    repeat (3) @(posedge clock_i);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({e, r[30:0]}, 32'h80000000);
    // hardware reset repeats the whole start-up
    rin_n_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    chk({31'h0, ro}, 32'h0);
    rin_n_i <= 1'b1;
    wait_up();
    chk({30'h0, cf, ro}, 32'h3);
    // supply loss drops both fault outputs
    vin_ok_i <= 1'b0;
    vin_low_i <= 1'b1;
    repeat (12) @(posedge clock_i);
    chk({30'h0, bf, cf}, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire

// file: hdl/prs_dev.sv
// module: power unit end, supply switching, fault outputs and reset timing
`timescale 1ns/10ps
`default_nettype none
// How it works
// - backup feeds always-on rail without main battery
// - 2-bit code selects 375/500/625 uA charge
// - host programs fault threshold and charge current
// - high-voltage enable switches on I/O group
// - low-voltage enable switches on core group
// - faults held low until supply above threshold
// - cold start: rail on, reset driven low
// - reset held 50 ms after rail valid
// - processor waits battery-fault release before enable
// - processor counts 125 ms between both enables
// - processor proceeds only if core fault released; host goes to PRS_H_DONE either way, raising IRQ_CORE_FAIL instead of IRQ_UP
// - core fault released within 120 ms
// - reset released 125 ms after low enable
// - reset asserted 100 us after battery-fault release
// - processor enables high voltage 10 ms after reset
// - reset input restarts the whole sequence
// - hardware reset holds reset low 50 ms
// - 3-bit code picks threshold pair
module prs_dev
  import prs_pkg::*;
#(
  parameter int unsigned HOLD_CYC  = RST_HOLD_CYC,
  parameter int unsigned F2R_CYC   = FLT2RST_CYC,
  parameter int unsigned CORE_CYC  = CORE_OK_CYC,
  parameter int unsigned LVREL_CYC = LV2RST_CYC
) (
  // clock and reset (reset comes from the backup-supply power-on)
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // link to the processor
  prs_link_if.dev   link,
  // analog status pins
  input  wire logic main_batt_present_i,
  input  wire logic vin_above_release_i,
  input  wire logic vin_below_assert_i,
  input  wire logic rtc_supply_valid_i,
  input  wire logic reset_in_n_i,
  // analog controls
  output logic      rtc_from_main_o,
  output logic      backup_charge_en_o,
  output logic [9:0] charge_ua_o,
  output logic [2:0] threshold_code_o,
  output logic      io_group_on_o,
  output logic      core_group_on_o,
  output logic [2:0] seq_state_o
);
  logic        main_s;
  logic        above_s;
  logic        below_s;
  logic        rtc_s;
  logic        rstin_s;
  logic        hv_s;
  logic        lv_s;
  prs_dev_st_t st_q;
  prs_dev_st_t st_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] lvcnt_q;
  logic        supply_ok_q;
  logic        batt_flt_n_q;
  logic        core_flt_n_q;
  logic        rst_out_n_q;

  // every status pin and both enables pass a synchroniser; the code fields do not
  prs_sync #(.RST_VAL(1'b0)) u_main  (.clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(main_batt_present_i),
                                      .level_o(main_s));
  prs_sync #(.RST_VAL(1'b0)) u_above (.clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(vin_above_release_i),
                                      .level_o(above_s));
  prs_sync #(.RST_VAL(1'b1)) u_below (.clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(vin_below_assert_i),
                                      .level_o(below_s));
  prs_sync #(.RST_VAL(1'b0)) u_rtc   (.clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(rtc_supply_valid_i),
                                      .level_o(rtc_s));
  prs_sync #(.RST_VAL(1'b1)) u_rstin (.clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(reset_in_n_i),
                                      .level_o(rstin_s));
  prs_sync #(.RST_VAL(1'b0)) u_hv    (.clock_i(clock_i), .rst_n_i(rst_n_i),
                                      .pin_i(link.high_voltage_supply_enable), .level_o(hv_s));
  prs_sync #(.RST_VAL(1'b0)) u_lv    (.clock_i(clock_i), .rst_n_i(rst_n_i),
                                      .pin_i(link.low_voltage_supply_enable), .level_o(lv_s));

  assign link.battery_fault_n     = batt_flt_n_q;
  assign link.core_supply_fault_n = core_flt_n_q;
  assign link.reset_out_n         = rst_out_n_q;

  // battery switch and charger follow the main battery
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rtc_from_main_o    <= 1'b0;
      backup_charge_en_o <= 1'b0;
    end else begin
      rtc_from_main_o    <= main_s;
      backup_charge_en_o <= main_s;
    end
  end

  // host-programmed codes; an out-of-range threshold falls back to the largest pair
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      charge_ua_o      <= CHG_UA_0;
      threshold_code_o <= THR_CODE_RST;
    end else begin
      charge_ua_o      <= prs_chg_ua(link.charge_current_setting);
      threshold_code_o <= (link.fault_threshold_code > THR_CODE_MAX) ? THR_CODE_MAX
                                                                      : link.fault_threshold_code;
    end
  end

  // hysteresis: ok above release level, lost below assert level
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      supply_ok_q <= 1'b0;
    end else if (above_s) begin
      supply_ok_q <= 1'b1;
    end else if (below_s) begin
      supply_ok_q <= 1'b0;
    end
  end

  // supply groups follow the enables while the input supply is good; not gated by the reset
  // output, since the core group must already be up while reset is held for the core settle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_group_on_o   <= 1'b0;
      core_group_on_o <= 1'b0;
    end else begin
      io_group_on_o   <= hv_s && supply_ok_q;
      core_group_on_o <= lv_s && supply_ok_q;
    end
  end

  // sequence state: a low reset input forces a restart from the hold
  always_comb begin
    st_d = st_q;
    case (st_q)
      PRS_HOLD:   if (rtc_s && cnt_q >= CNT_W'(HOLD_CYC - 1)) st_d = PRS_WAITV;
      PRS_WAITV:  if (supply_ok_q) st_d = PRS_DLY;
      PRS_DLY:    if (cnt_q >= CNT_W'(F2R_CYC - 1)) st_d = PRS_WAITLV;
      PRS_WAITLV: if (lv_s) st_d = PRS_LVRUN;
      PRS_LVRUN:  if (lvcnt_q >= CNT_W'(LVREL_CYC - 1)) st_d = PRS_RUN;
      PRS_RUN:    st_d = PRS_RUN;
      default:    st_d = PRS_HOLD;
    endcase
    if (!rstin_s || (!supply_ok_q && st_q != PRS_HOLD && st_q != PRS_WAITV)) begin
      st_d = PRS_HOLD;
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= PRS_HOLD;
    end else begin
      st_q <= st_d;
    end
  end

  // general counter, cleared on each state change; rail must be valid to count the hold
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (st_d != st_q || (st_q == PRS_HOLD && !rtc_s)) begin
      cnt_q <= '0;
    end else if (cnt_q != {CNT_W{1'b1}}) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // low-voltage counter, runs from the low enable until reset release
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvcnt_q <= '0;
    end else if (st_q != PRS_LVRUN) begin
      lvcnt_q <= '0;
    end else if (lvcnt_q != {CNT_W{1'b1}}) begin
      lvcnt_q <= lvcnt_q + 1'b1;
    end
  end

  // battery fault: released as soon as the supply is present
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      batt_flt_n_q <= 1'b0;
    end else begin
      batt_flt_n_q <= supply_ok_q;
    end
  end

  // core fault: released once core regulators settle, at most 120 ms after low enable
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_flt_n_q <= 1'b0;
    end else if (!supply_ok_q || !lv_s || st_q == PRS_HOLD) begin
      core_flt_n_q <= 1'b0;
    end else if ((st_q == PRS_LVRUN && lvcnt_q >= CNT_W'(CORE_CYC - 1)) || st_q == PRS_RUN) begin
      core_flt_n_q <= 1'b1;
    end
  end

  // reset output: released after hold, asserted again 100 us after fault release, freed after low run
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_out_n_q <= 1'b0;
    end else begin
      case (st_d)
        PRS_HOLD:   rst_out_n_q <= 1'b0;
        PRS_WAITV:  rst_out_n_q <= 1'b1;
        PRS_DLY:    rst_out_n_q <= 1'b1;
        PRS_WAITLV: rst_out_n_q <= 1'b0;
        PRS_LVRUN:  rst_out_n_q <= 1'b0;
        PRS_RUN:    rst_out_n_q <= 1'b1;
        default:    rst_out_n_q <= 1'b0;
      endcase
    end
  end

  // coarse state index for observation
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_state_o <= 3'h0;
    end else begin
      case (st_q)
        PRS_HOLD:   seq_state_o <= 3'h0;
        PRS_WAITV:  seq_state_o <= 3'h1;
        PRS_DLY:    seq_state_o <= 3'h2;
        PRS_WAITLV: seq_state_o <= 3'h3;
        PRS_LVRUN:  seq_state_o <= 3'h4;
        PRS_RUN:    seq_state_o <= 3'h5;
        default:    seq_state_o <= 3'h7;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: hdl/prs_host.sv
// module: processor end, drives supply enables and programs codes, APB registers for software
`timescale 1ns/10ps
`default_nettype none
module prs_host
  import prs_pkg::*;
#(
  parameter int unsigned HV_CYC  = HOST_HV_CYC,
  parameter int unsigned CNT_CYC = HOST_CNT_CYC
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // link to the power unit
  prs_link_if.host         link,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // interrupt
  output logic             irq_o
);
  logic             bf_s;
  logic             cf_s;
  logic             ro_s;
  prs_host_st_t     st_q;
  logic [CNT_W-1:0] cnt_q;
  logic [1:0]       chg_q;
  logic [2:0]       thr_q;
  logic [IRQ_W-1:0] ist_q;
  logic [IRQ_W-1:0] ien_q;
  logic [IRQ_W-1:0] ev;
  logic             hv_q;
  logic             lv_q;
  logic             ro_d_q;
  logic             wr;
  logic             rd;

  prs_sync #(.RST_VAL(1'b0)) u_bf (.clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(link.battery_fault_n),
                                   .level_o(bf_s));
  prs_sync #(.RST_VAL(1'b0)) u_cf (.clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(link.core_supply_fault_n),
                                   .level_o(cf_s));
  prs_sync #(.RST_VAL(1'b0)) u_ro (.clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(link.reset_out_n),
                                   .level_o(ro_s));

  assign link.high_voltage_supply_enable = hv_q;
  assign link.low_voltage_supply_enable  = lv_q;
  assign link.charge_current_setting     = chg_q;
  assign link.fault_threshold_code       = thr_q;
  assign wr = psel_i && penable_i && pwrite_i;
  assign rd = psel_i && !penable_i && !pwrite_i;

  // start-up sequence; the unit pulses reset low just after fault release and then waits for
  // the enables, so only a low reset before that point or a fall once up restarts the count
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= PRS_H_RST;
      cnt_q <= '0;
      hv_q <= 1'b0;
      lv_q <= 1'b0;
    end else if ((!ro_s && (st_q == PRS_H_RST || st_q == PRS_H_FLT)) ||
                 (ro_d_q && !ro_s && st_q == PRS_H_DONE)) begin
      st_q <= PRS_H_RST;
      cnt_q <= '0;
      hv_q <= 1'b0;
      lv_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      case (st_q)
        PRS_H_RST: begin
          st_q  <= PRS_H_FLT;
          cnt_q <= '0;
        end
        PRS_H_FLT: begin
          cnt_q <= '0;
          if (bf_s) st_q <= PRS_H_HVW;
        end
        PRS_H_HVW: if (cnt_q >= CNT_W'(HV_CYC - 1)) begin
          st_q  <= PRS_H_HV;
          hv_q  <= 1'b1;
          cnt_q <= '0;
        end
        PRS_H_HV: if (cnt_q >= CNT_W'(CNT_CYC - 1)) begin
          st_q  <= PRS_H_LV;
          lv_q  <= 1'b1;
          cnt_q <= '0;
        end
        PRS_H_LV: if (cnt_q >= CNT_W'(CNT_CYC - 1)) begin
          st_q  <= PRS_H_DONE;
          cnt_q <= '0;
        end
        PRS_H_DONE: cnt_q <= '0;
        default: st_q <= PRS_H_RST;
      endcase
    end
  end

  // events: up when countdown ends with core ok, fail otherwise, reset from unit
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ro_d_q <= 1'b0;
    end else begin
      ro_d_q <= ro_s;
    end
  end
  always_comb begin
    ev = '0;
    ev[IRQ_UP]        = (st_q == PRS_H_LV) && (cnt_q >= CNT_W'(CNT_CYC - 1)) && cf_s;
    ev[IRQ_CORE_FAIL] = (st_q == PRS_H_LV) && (cnt_q >= CNT_W'(CNT_CYC - 1)) && !cf_s;
    ev[IRQ_RST]       = ro_d_q && !ro_s;
  end

  // programmable codes and interrupt state; set wins over clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chg_q <= CHG_CODE_RST;
      thr_q <= THR_CODE_RST;
      ien_q <= '0;
      ist_q <= '0;
    end else begin
      if (wr && paddr_i == REG_CTRL) begin
        chg_q <= pwdata_i[1:0];
        thr_q <= pwdata_i[4:2];
      end
      if (wr && paddr_i == REG_IRQ_EN) ien_q <= pwdata_i[IRQ_W-1:0];
      ist_q <= (ist_q & ~((wr && paddr_i == REG_IRQ_CLR) ? pwdata_i[IRQ_W-1:0] : '0)) | ev;
    end
  end

  // apb answer: ready in the access cycle, read data loaded in setup
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      irq_o     <= 1'b0;
    end else begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !(paddr_i inside {REG_CTRL, REG_STAT, REG_IRQ_STAT,
                                                             REG_IRQ_CLR, REG_IRQ_EN});
      irq_o     <= |(ist_q & ien_q);
      if (rd) begin
        case (paddr_i)
          REG_CTRL:     prdata_o <= {27'h0, thr_q, chg_q};
          REG_STAT:     prdata_o <= {21'h0, st_q, hv_q, lv_q, ro_s, cf_s, bf_s};
          REG_IRQ_STAT: prdata_o <= {29'h0, ist_q};
          REG_IRQ_EN:   prdata_o <= {29'h0, ien_q};
          default:      prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/prs_link_if.sv
// interface: pins between the power unit and the processor
`timescale 1ns/10ps
`default_nettype none
interface prs_link_if;
  logic       high_voltage_supply_enable;
  logic       low_voltage_supply_enable;
  logic       battery_fault_n;
  logic       core_supply_fault_n;
  logic       reset_out_n;
  logic [1:0] charge_current_setting;
  logic [2:0] fault_threshold_code;

  modport dev (
    input  high_voltage_supply_enable,
    input  low_voltage_supply_enable,
    input  charge_current_setting,
    input  fault_threshold_code,
    output battery_fault_n,
    output core_supply_fault_n,
    output reset_out_n
  );
  modport host (
    output high_voltage_supply_enable,
    output low_voltage_supply_enable,
    output charge_current_setting,
    output fault_threshold_code,
    input  battery_fault_n,
    input  core_supply_fault_n,
    input  reset_out_n
  );
endinterface
`default_nettype wire

// file: hdl/prs_pkg.sv
// package: timing constants, code tables and states of the power/reset sequencer
package prs_pkg;
  // clock
  localparam int unsigned CLK_HZ          = 20_000_000;
  // reset hold after always-on supply valid or reset input, in ms
  localparam int unsigned RST_HOLD_MS     = 50;
  localparam int unsigned RST_HOLD_CYC    = (RST_HOLD_MS * (CLK_HZ / 1000));
  // battery-fault release to reset assertion, in us
  localparam int unsigned FLT2RST_US      = 100;
  localparam int unsigned FLT2RST_CYC     = (FLT2RST_US * (CLK_HZ / 1_000_000));
  // low-voltage enable to core fault release, longest, in ms
  localparam int unsigned CORE_OK_MS      = 120;
  localparam int unsigned CORE_OK_CYC     = (CORE_OK_MS * (CLK_HZ / 1000));
  // low-voltage enable to reset release, typical, in ms
  localparam int unsigned LV2RST_MS       = 125;
  localparam int unsigned LV2RST_CYC      = (LV2RST_MS * (CLK_HZ / 1000));
  // host-side countdowns, in ms
  localparam int unsigned HOST_HV_WAIT_MS = 10;
  localparam int unsigned HOST_HV_CYC     = (HOST_HV_WAIT_MS * (CLK_HZ / 1000));
  localparam int unsigned HOST_CNT_MS     = 125;
  localparam int unsigned HOST_CNT_CYC    = (HOST_CNT_MS * (CLK_HZ / 1000));
  // counter width, enough for every count above
  localparam int unsigned CNT_W           = 23;
  // code fields and reset values
  localparam int unsigned CHG_CODE_W      = 2;
  localparam int unsigned THR_CODE_W      = 3;
  localparam logic [1:0]  CHG_CODE_RST    = 2'h0;
  localparam logic [2:0]  THR_CODE_RST    = 3'h0;
  localparam logic [2:0]  THR_CODE_MAX    = 3'h5;
  // charge current in uA per code
  localparam logic [9:0]  CHG_UA_0        = 10'h177;
  localparam logic [9:0]  CHG_UA_1        = 10'h1F4;
  localparam logic [9:0]  CHG_UA_2        = 10'h271;
  // host APB register offsets
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_STAT        = 8'h04;
  localparam logic [7:0]  REG_IRQ_STAT    = 8'h08;
  localparam logic [7:0]  REG_IRQ_CLR     = 8'h0C;
  localparam logic [7:0]  REG_IRQ_EN      = 8'h10;
  // interrupt bits
  localparam int unsigned IRQ_W           = 3;
  localparam int unsigned IRQ_UP          = 0;
  localparam int unsigned IRQ_CORE_FAIL   = 1;
  localparam int unsigned IRQ_RST         = 2;

  // device sequencer states
  typedef enum logic [5:0] {
    PRS_HOLD   = 6'b000001,
    PRS_WAITV  = 6'b000010,
    PRS_DLY    = 6'b000100,
    PRS_WAITLV = 6'b001000,
    PRS_LVRUN  = 6'b010000,
    PRS_RUN    = 6'b100000
  } prs_dev_st_t;

  // host sequencer states
  typedef enum logic [5:0] {
    PRS_H_RST  = 6'b000001,
    PRS_H_FLT  = 6'b000010,
    PRS_H_HVW  = 6'b000100,
    PRS_H_HV   = 6'b001000,
    PRS_H_LV   = 6'b010000,
    PRS_H_DONE = 6'b100000
  } prs_host_st_t;

  // charge current in uA for a code; reserved code 3 reads 0
  function automatic logic [9:0] prs_chg_ua(input logic [1:0] code);
    case (code)
      2'h0:    prs_chg_ua = CHG_UA_0;
      2'h1:    prs_chg_ua = CHG_UA_1;
      2'h2:    prs_chg_ua = CHG_UA_2;
      default: prs_chg_ua = 10'h000;
    endcase
  endfunction
endpackage

// file: hdl/prs_sync.sv
// module: three-flop pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module prs_sync
  import prs_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // pin and filtered level
  input  wire logic pin_i,
  output logic      level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // shift chain; only s2_q reads the first stage
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // level follows only once two stages agree
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= RST_VAL;
    end else if (s2_q == s3_q) begin
      level_o <= s3_q;
    end
  end
endmodule
`default_nettype wire
